// file: hdl/fpc_top.sv
`timescale 1ns/10ps
`include "fpc_regs.svh"
module fpc_top #(
   parameter int unsigned MS_CYCLES = `FPC_CLK_HZ / `FPC_MS_PER_S,
   parameter int unsigned TACH_TICK_CYCLES = `FPC_CLK_HZ / `FPC_TACH_TICK_HZ
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Override and power-up pins
   input wire logic force_max_n_i,
   input wire logic [1:0] powerup_duty_sel_i,
   input wire logic standby_i,
   // Fan pins: open-drain outputs that double as tach inputs
   input wire logic [5:0] fan_pwm_out_i,
   output logic [5:0] fan_pwm_out_o,
   output logic [5:0] fan_pwm_out_oe_o,
   input wire logic [5:0] tach_in_i,
   // Per-channel control
   input wire logic [5:0] pwm_as_tach_i,
   input wire logic [5:0] rpm_mode_i,
   input wire logic [17:0] rate_sel_i,
   input wire logic [65:0] tach_target_i,
   input wire logic [5:0] duty_wr_i,
   input wire logic [8:0] duty_wdata_i,
   input wire logic [5:0] zero_on_fail_i,
   input wire logic [2:0] seq_delay_sel_i,
   // Channel status
   output logic [53:0] duty_o,
   output logic [65:0] tach_count_o,
   // Fault reporting
   input wire logic [5:0] fault_event_i,
   input wire logic [5:0] fault_clear_i,
   input wire logic [5:0] fault_mask_i,
   input wire logic [1:0] fault_limit_sel_i,
   output logic [5:0] fan_failed_o,
   output logic fan_fault_n_o,
   output logic fan_fault_n_oe_o,
   // Oscillator
   input wire logic crystal_enable_i,
   input wire logic crystal_in_i,
   output logic crystal_out_o,
   output logic osc_clock_out_o
);

   localparam int unsigned OSC_HALF = `FPC_CLK_HZ / (2 * `FPC_OSC_HZ);

   fpc_pkg::fpc_top_t s;
   fpc_pkg::fpc_top_t next_s;
   logic [2:0] lim;

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   // Time bases, pin synchronisers, power-up latch, start sequence and fault counts.
   always_comb begin
      next_s = s;
      lim = fpc_pkg::fault_limit(fault_limit_sel_i);
      next_s.init_load = 1'b0;
      next_s.ms_tick = 1'b0;
      next_s.tt_tick = 1'b0;
      next_s.pwm_cnt = (s.pwm_cnt == `FPC_DUTY_FULL - 9'h001) ? 9'h000 : s.pwm_cnt + 9'h001;
      if (s.ms_cnt == 18'(MS_CYCLES - 1)) begin
         next_s.ms_cnt = 18'h00000;
         next_s.ms_tick = 1'b1;
      end else begin
         next_s.ms_cnt = s.ms_cnt + 18'h00001;
      end
      if (s.tt_cnt == 15'(TACH_TICK_CYCLES - 1)) begin
         next_s.tt_cnt = 15'h0000;
         next_s.tt_tick = 1'b1;
      end else begin
         next_s.tt_cnt = s.tt_cnt + 15'h0001;
      end
      // Internal oscillator: divided core clock, free running from reset.
      if (s.osc_cnt == 12'(OSC_HALF - 1)) begin
         next_s.osc_cnt = 12'h000;
         next_s.osc_int = ~s.osc_int; // RL5
      end else begin
         next_s.osc_cnt = s.osc_cnt + 12'h001;
      end
      // Crystal path; the clock output has no off state, only a source switch.
      next_s.xsync = {s.xsync[1:0], crystal_in_i};
      if (s.xsync[1] == s.xsync[2]) begin
         next_s.xstable = s.xsync[2];
      end
      next_s.osc_out = crystal_enable_i ? s.xstable : s.osc_int; // RL5 RL6
      next_s.xtal_drv = crystal_enable_i & ~s.xstable;
      // Force pin is active low; the flops hold it inverted so that their cleared state
      // reads as an idle pin and reset cannot start a false force.
      next_s.fsync = {s.fsync[1:0], ~force_max_n_i};
      if (s.fsync[1] == s.fsync[2]) begin
         next_s.force_on = s.fsync[2];
      end
      // Select pins are latched exactly once, after the synchroniser has filled.
      next_s.psync = {s.psync[1:0], powerup_duty_sel_i};
      if (!s.pu_done) begin
         if (s.pu_cnt != `FPC_SYNC_SETTLE) begin
            next_s.pu_cnt = s.pu_cnt + 2'h1;
         end else if (s.psync[1] == s.psync[2]) begin
            next_s.pu_done = 1'b1; // RL4
            next_s.init_load = 1'b1;
            case (s.psync[2])
               2'h0: next_s.pu_duty = `FPC_PU_DUTY_0; // RL13
               2'h1: next_s.pu_duty = `FPC_PU_DUTY_1;
               2'h2: next_s.pu_duty = `FPC_PU_DUTY_2;
               default: next_s.pu_duty = `FPC_PU_DUTY_3;
            endcase
         end
      end
      // Start sequence: channel 1 first, then one more per elapsed delay.
      case (s.seq)
         fpc_pkg::SEQ_IDLE: begin
            next_s.act = 6'h00;
            if (s.force_on) begin
               next_s.seq = fpc_pkg::SEQ_RUN;
               next_s.seq_idx = 3'h0;
               // Start above every delay so channel 1 goes at once.
               next_s.seq_ms = 12'hFFF; // RL10
            end
         end
         fpc_pkg::SEQ_RUN: begin
            if (!s.force_on) begin
               next_s.seq = fpc_pkg::SEQ_IDLE;
               next_s.act = 6'h00;
            end else if (s.seq_ms >= fpc_pkg::seq_delay_ms(seq_delay_sel_i)) begin
               next_s.act[s.seq_idx] = 1'b1; // RL10
               next_s.seq_ms = 12'h000;
               if (s.seq_idx == `FPC_LAST_CHAN) begin
                  next_s.seq = fpc_pkg::SEQ_DONE;
               end else begin
                  next_s.seq_idx = s.seq_idx + 3'h1;
               end
            end else if (s.ms_tick) begin
               next_s.seq_ms = s.seq_ms + 12'h001;
            end
         end
         fpc_pkg::SEQ_DONE: begin
            if (!s.force_on) begin
               next_s.seq = fpc_pkg::SEQ_IDLE;
               next_s.act = 6'h00;
            end
         end
         default: begin
            next_s.seq = fpc_pkg::SEQ_IDLE;
         end
      endcase
      // A detection in the same cycle as a clear is counted after the clear.
      for (int c = 0; c < 6; c++) begin
         if (fault_clear_i[c]) begin
            next_s.fail_cnt[c] = 3'h0;
            next_s.failed[c] = 1'b0;
         end
         if (fault_event_i[c]) begin
            if (next_s.fail_cnt[c] != `FPC_FAIL_MAX) begin
               next_s.fail_cnt[c] = next_s.fail_cnt[c] + 3'h1;
            end
            if (next_s.fail_cnt[c] >= lim) begin
               next_s.failed[c] = 1'b1; // RL12
            end
         end
      end
      next_s.fault_oe = |(next_s.failed & ~fault_mask_i); // RL3 RL12
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // -------------------------------------------------------------------------
   // Channels
   // -------------------------------------------------------------------------
   // The pin doubles as the tach source when turned around.
   for (genvar c = 0; c < 6; c++) begin : g_chan
      fpc_channel u_chan (
         .core_clk_i(core_clk_i),
         .rst_i(rst_i),
         .pwm_cnt_i(s.pwm_cnt),
         .ms_tick_i(s.ms_tick),
         .tach_tick_i(s.tt_tick),
         .rate_sel_i(rate_sel_i[3*c +: 3]),
         .rpm_mode_i(rpm_mode_i[c]),
         .tach_target_i(tach_target_i[11*c +: 11]),
         .sw_wr_i(duty_wr_i[c]),
         .sw_duty_i(duty_wdata_i),
         .init_load_i(s.init_load),
         .init_duty_i(s.pu_duty),
         .forced_i(s.force_on & s.act[c]),
         .zero_i(s.failed[c] & zero_on_fail_i[c]),
         .standby_i(standby_i),
         .as_tach_i(pwm_as_tach_i[c]),
         .tach_pin_i(pwm_as_tach_i[c] ? fan_pwm_out_i[c] : tach_in_i[c]),
         .pwm_oe_o(fan_pwm_out_oe_o[c]),
         .duty_o(duty_o[9*c +: 9]),
         .tach_count_o(tach_count_o[11*c +: 11])
      );
   end

   // Open-drain pins only ever drive low.
   assign fan_pwm_out_o = 6'h00;
   assign fan_fault_n_o = 1'b0;
   assign fan_fault_n_oe_o = s.fault_oe;
   assign fan_failed_o = s.failed;
   assign osc_clock_out_o = s.osc_out;
   assign crystal_out_o = s.xtal_drv;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_fault_pin_level: assert property (##1 fan_fault_n_oe_o == |(s.failed & ~$past(fault_mask_i))) else $error("fault pin does not match faults"); // RL3
   a_fault_needs_count: assert property (!s.failed[0] && !fault_clear_i[0] ##1 s.failed[0] |-> $past(fault_event_i[0]) && $past(s.fail_cnt[0]) + 3'h1 >= $past(lim)) else $error("fault set too early"); // RL12
   a_powerup_once: assert property (s.pu_done |-> ##1 !s.init_load && s.pu_done) else $error("power-up duty relatched"); // RL4
   a_powerup_table: assert property ($rose(s.pu_done) |-> s.pu_duty != `FPC_PU_DUTY_3 || $past(s.psync[2]) == 2'h3) else $error("wrong power-up duty entry"); // RL13
   a_osc_internal: assert property (!crystal_enable_i |=> osc_clock_out_o == $past(s.osc_int)) else $error("clock not from internal source"); // RL5
   a_osc_crystal: assert property (crystal_enable_i |=> osc_clock_out_o == $past(s.xstable)) else $error("clock not from crystal"); // RL6
   a_seq_in_order: assert property ($changed(s.act) && s.act != 6'h00 |-> ((s.act + 6'h01) & s.act) == 6'h00 && $countones(s.act ^ $past(s.act)) == 1) else $error("channels started out of order"); // RL10
   a_force_clears_seq: assert property (!s.force_on |=> s.act == 6'h00 || s.seq == fpc_pkg::SEQ_IDLE) else $error("sequence kept without force"); // RL1
   c_force_all: cover property (s.force_on ##1 s.act == 6'h3F);
   c_fault_pin: cover property ($rose(fan_fault_n_oe_o));
   c_crystal_on: cover property (crystal_enable_i ##1 osc_clock_out_o);

endmodule // fpc_top

// file: hdl/fpc_regs.svh
// Operation
// [RL1] Force-max input held low drives every fan output at full duty.
// [RL2] A failed fan with zero-on-failure selected stays at zero duty despite force.
// [RL3] Fault output pulls low only while an unmasked fan fault is present.
// [RL4] Both power-up duty select pins are sampled once to choose initial duty.
// [RL5] Without crystal, clock output comes from the internal 32768 Hz oscillator.
// [RL6] With crystal enabled, clock output follows the crystal; it is never disabled.
// [RL7] Each fan output pin can be turned into a tach input instead.
// [RL8] Tach pulses give speed feedback for closed-loop speed control per fan.
// [RL9] Forced duty still ramps toward full at the programmed rate of change.
// [RL10] On force, channels activate one by one, spaced by the sequential delay.
// [RL11] The force override keeps working in standby.
// [RL12] Fault output asserts only after a selectable count of unmasked fault detections.
// [RL13] Select pins index a four-entry duty table, held until software writes targets.
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define FPC_CLK_HZ 250000000
`define FPC_OSC_HZ 32768
`define FPC_TACH_TICK_HZ 8192
`define FPC_MS_PER_S 1000
`define FPC_SYNC_SETTLE 2'h3

// -----------------------------------------------------------------------------
// Duty values, channel and counter limits
// -----------------------------------------------------------------------------
`define FPC_DUTY_FULL 9'h1FF
`define FPC_DUTY_ZERO 9'h000
`define FPC_PU_DUTY_0 9'h000
`define FPC_PU_DUTY_1 9'h0CC
`define FPC_PU_DUTY_2 9'h133
`define FPC_PU_DUTY_3 9'h1FF
`define FPC_LAST_CHAN 3'h5
`define FPC_TACH_MAX 11'h7FF
`define FPC_FAIL_MAX 3'h7

`endif

// file: hdl/fpc_pkg.sv
`include "fpc_regs.svh"
package fpc_pkg;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} fpc_seq_t;

   typedef struct packed {
      logic [2:0] tsync;
      logic tstable;
      logic [8:0] duty;
      logic [8:0] sw_tgt;
      logic [8:0] rpm_tgt;
      logic [6:0] step_cnt;
      logic [10:0] tach_cnt;
      logic [10:0] tach_last;
      logic drive_low;
   } fpc_chan_t;

   typedef struct packed {
      logic [2:0] fsync;
      logic force_on;
      logic [2:0][1:0] psync;
      logic [1:0] pu_cnt;
      logic pu_done;
      logic init_load;
      logic [8:0] pu_duty;
      logic [17:0] ms_cnt;
      logic ms_tick;
      logic [14:0] tt_cnt;
      logic tt_tick;
      logic [11:0] osc_cnt;
      logic osc_int;
      logic [2:0] xsync;
      logic xstable;
      logic osc_out;
      logic xtal_drv;
      fpc_seq_t seq;
      logic [11:0] seq_ms;
      logic [2:0] seq_idx;
      logic [5:0] act;
      logic [5:0][2:0] fail_cnt;
      logic [5:0] failed;
      logic fault_oe;
      logic [8:0] pwm_cnt;
   } fpc_top_t;

   // Milliseconds per duty step; zero means jump straight to the target.
   function automatic logic [6:0] rate_ms(input logic [2:0] sel);
      case (sel)
         3'h0: rate_ms = 7'h00;
         3'h1: rate_ms = 7'h01;
         3'h2: rate_ms = 7'h02;
         3'h3: rate_ms = 7'h04;
         3'h4: rate_ms = 7'h08;
         3'h5: rate_ms = 7'h10;
         3'h6: rate_ms = 7'h20;
         default: rate_ms = 7'h7D;
      endcase
   endfunction

   // Sequential start spacing in milliseconds.
   function automatic logic [11:0] seq_delay_ms(input logic [2:0] sel);
      case (sel)
         3'h0: seq_delay_ms = 12'h000;
         3'h1: seq_delay_ms = 12'h0FA;
         3'h2: seq_delay_ms = 12'h1F4;
         3'h3: seq_delay_ms = 12'h3E8;
         3'h4: seq_delay_ms = 12'h7D0;
         default: seq_delay_ms = 12'hFA0;
      endcase
   endfunction

   // Number of fault detections that make a fan count as failed.
   function automatic logic [2:0] fault_limit(input logic [1:0] sel);
      case (sel)
         2'h0: fault_limit = 3'h1;
         2'h1: fault_limit = 3'h2;
         2'h2: fault_limit = 3'h4;
         default: fault_limit = 3'h6;
      endcase
   endfunction

endpackage

// file: hdl/fpc_channel.sv
`timescale 1ns/10ps
`include "fpc_regs.svh"
module fpc_channel (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Shared time base
   input wire logic [8:0] pwm_cnt_i,
   input wire logic ms_tick_i,
   input wire logic tach_tick_i,
   // Control
   input wire logic [2:0] rate_sel_i,
   input wire logic rpm_mode_i,
   input wire logic [10:0] tach_target_i,
   input wire logic sw_wr_i,
   input wire logic [8:0] sw_duty_i,
   input wire logic init_load_i,
   input wire logic [8:0] init_duty_i,
   input wire logic forced_i,
   input wire logic zero_i,
   input wire logic standby_i,
   input wire logic as_tach_i,
   // Pins and status
   input wire logic tach_pin_i,
   output logic pwm_oe_o,
   output logic [8:0] duty_o,
   output logic [10:0] tach_count_o
);

   fpc_pkg::fpc_chan_t s;
   fpc_pkg::fpc_chan_t next_s;
   logic tedge;
   logic [8:0] tgt;
   logic [6:0] step;

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   // Target priority: failure-zero, then force, then standby, then loop or software.
   always_comb begin
      next_s = s;
      tedge = 1'b0;
      step = fpc_pkg::rate_ms(rate_sel_i);
      // The synchroniser holds the inverted pin, so its cleared state matches an idle
      // pulled-up line and no false tach edge follows reset.
      next_s.tsync = {s.tsync[1:0], ~tach_pin_i};
      if (s.tsync[1] == s.tsync[2]) begin
         next_s.tstable = s.tsync[2];
         tedge = ~s.tsync[2] & s.tstable;
      end
      if (tach_tick_i && s.tach_cnt != `FPC_TACH_MAX) begin
         next_s.tach_cnt = s.tach_cnt + 11'h001;
      end
      // Each tach period nudges the loop target toward the wanted count.
      if (tedge) begin
         next_s.tach_last = s.tach_cnt;
         next_s.tach_cnt = 11'h000;
         if (rpm_mode_i && s.tach_cnt > tach_target_i && s.rpm_tgt != `FPC_DUTY_FULL) begin
            next_s.rpm_tgt = s.rpm_tgt + 9'h001; // RL8
         end else if (rpm_mode_i && s.tach_cnt < tach_target_i && s.rpm_tgt != `FPC_DUTY_ZERO) begin
            next_s.rpm_tgt = s.rpm_tgt - 9'h001; // RL8
         end
      end
      if (init_load_i) begin
         next_s.sw_tgt = init_duty_i; // RL13
         next_s.rpm_tgt = init_duty_i;
      end
      if (sw_wr_i) begin
         next_s.sw_tgt = sw_duty_i; // RL13
      end
      if (zero_i) begin
         tgt = `FPC_DUTY_ZERO; // RL2
      end else if (forced_i) begin
         tgt = `FPC_DUTY_FULL; // RL1 RL11
      end else if (standby_i) begin
         tgt = `FPC_DUTY_ZERO;
      end else if (rpm_mode_i) begin
         tgt = s.rpm_tgt;
      end else begin
         tgt = s.sw_tgt;
      end
      // Duty walks one step per rate period, even when forced.
      if (step == 7'h00) begin
         next_s.duty = tgt;
         next_s.step_cnt = 7'h00;
      end else if (ms_tick_i) begin
         if (s.step_cnt + 7'h01 >= step) begin
            next_s.step_cnt = 7'h00;
            if (s.duty < tgt) begin
               next_s.duty = s.duty + 9'h001; // RL9
            end else if (s.duty > tgt) begin
               next_s.duty = s.duty - 9'h001;
            end
         end else begin
            next_s.step_cnt = s.step_cnt + 7'h01;
         end
      end
      // Open drain: pull low in the low phase, let go when used as a tach input.
      next_s.drive_low = ~as_tach_i & ~(pwm_cnt_i < s.duty); // RL7
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign pwm_oe_o = s.drive_low;
   assign duty_o = s.duty;
   assign tach_count_o = s.tach_last;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_force_full_duty: assert property (forced_i && !zero_i && rate_sel_i == 3'h0 |=> duty_o == `FPC_DUTY_FULL) else $error("forced channel not at full duty"); // RL1
   a_fail_zero_duty: assert property (zero_i && rate_sel_i == 3'h0 |=> duty_o == `FPC_DUTY_ZERO) else $error("failed channel not at zero duty"); // RL2
   a_forced_ramp_step: assert property (forced_i && !zero_i && rate_sel_i != 3'h0 |=> duty_o == $past(duty_o) || duty_o == $past(duty_o) + 9'h001) else $error("forced duty jumped"); // RL9
   a_tach_pin_released: assert property (as_tach_i |=> !pwm_oe_o) else $error("tach pin still driven"); // RL7
   a_standby_override: assert property (standby_i && forced_i && !zero_i && rate_sel_i == 3'h0 ##1 standby_i |-> duty_o == `FPC_DUTY_FULL) else $error("force lost in standby"); // RL11
   a_rpm_slow_raise: assert property (tedge && rpm_mode_i && s.tach_cnt > tach_target_i && s.rpm_tgt != `FPC_DUTY_FULL && !init_load_i |=> s.rpm_tgt == $past(s.rpm_tgt) + 9'h001) else $error("loop did not raise duty"); // RL8
   c_forced_ramp: cover property (forced_i && rate_sel_i != 3'h0 ##1 duty_o == `FPC_DUTY_FULL);

endmodule // fpc_channel

// file: test/fpc_fan_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Fan bank model
// ---------------------------------------------------------------------------
module fpc_fan_model #(
   parameter int unsigned HALF = 200
) (
   // Clock
   input wire logic core_clk_i,
   // Fan side
   input wire logic [5:0] run_i,
   output logic [5:0] tach_o
);
   int unsigned cnt = 0;

   // A running fan gives a logic-level square wave; a stopped one lets the pull-up win.
   always @(posedge core_clk_i) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
         tach_o <= (~tach_o & run_i) | ~run_i;
      end
   end

   // The tach line idles high through its pull-up before the first half period.
   initial tach_o = 6'h3F;
endmodule // fpc_fan_model

// file: test/fpc_top_tb.sv
`timescale 1ns/10ps
module fpc_top_tb;
   // ------------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------------
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic force_max_n_i = 1'b1;
   logic standby_i = 1'b0;
   logic crystal_enable_i = 1'b0;
   logic crystal_in_i = 1'b0;
   logic [1:0] powerup_duty_sel_i = 2'h2;
   logic [1:0] fault_limit_sel_i = 2'h0;
   logic [2:0] seq_delay_sel_i = 3'h1;
   logic [5:0] pwm_as_tach_i = 6'h00, duty_wr_i = 6'h00, zero_on_fail_i = 6'h00;
   logic [5:0] fault_event_i = 6'h00, fault_clear_i = 6'h00, fault_mask_i = 6'h00;
   logic [5:0] rpm_mode_i = 6'h00;
   logic [5:0] fan_pwm_out_i, fan_pwm_out_oe_o, tach_in_i, fan_failed_o, fan_pwm_out_o;
   logic [8:0] duty_wdata_i = 9'h000;
   logic [17:0] rate_sel_i = 18'h00000;
   logic [53:0] duty_o;
   logic [65:0] tach_target_i = 66'h0;
   logic [65:0] tach_count_o;
   logic fan_fault_n_oe_o, osc_clock_out_o, fan_fault_n_o, crystal_out_o;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc_n = 0;
   int t [6];
   int p;
   localparam logic [8:0] ROWS [6] = '{9'h1FF, 9'h000, 9'h0CC, 9'h001, 9'h1FE, 9'h133};

   // Clock, cycle counter and a crystal that runs at 40 core cycles a period.
   always #2 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) cyc_n <= cyc_n + 1;
   initial forever begin
      cyc(20);
      crystal_in_i = ~crystal_in_i;
   end

   // Turned-around pins carry the fan's tach; the others read the pull-up against the driver.
   assign fan_pwm_out_i = (pwm_as_tach_i & tach_in_i) | (~pwm_as_tach_i & ~fan_pwm_out_oe_o);

   // Short time bases keep the millisecond-scale sequences inside a brief run.
   fpc_top #(.MS_CYCLES(10), .TACH_TICK_CYCLES(8)) uut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .force_max_n_i(force_max_n_i),
      .powerup_duty_sel_i(powerup_duty_sel_i), .standby_i(standby_i),
      .fan_pwm_out_i(fan_pwm_out_i), .fan_pwm_out_o(fan_pwm_out_o),
      .fan_pwm_out_oe_o(fan_pwm_out_oe_o),
      .tach_in_i(tach_in_i), .pwm_as_tach_i(pwm_as_tach_i), .rpm_mode_i(rpm_mode_i),
      .rate_sel_i(rate_sel_i), .tach_target_i(tach_target_i), .duty_wr_i(duty_wr_i),
      .duty_wdata_i(duty_wdata_i), .zero_on_fail_i(zero_on_fail_i),
      .seq_delay_sel_i(seq_delay_sel_i), .duty_o(duty_o), .tach_count_o(tach_count_o),
      .fault_event_i(fault_event_i), .fault_clear_i(fault_clear_i),
      .fault_mask_i(fault_mask_i), .fault_limit_sel_i(fault_limit_sel_i),
      .fan_failed_o(fan_failed_o), .fan_fault_n_o(fan_fault_n_o),
      .fan_fault_n_oe_o(fan_fault_n_oe_o),
      .crystal_enable_i(crystal_enable_i), .crystal_in_i(crystal_in_i),
      .crystal_out_o(crystal_out_o),
      .osc_clock_out_o(osc_clock_out_o)
   );

   fpc_fan_model #(.HALF(200)) fans (
      .core_clk_i(core_clk_i),
      .run_i(6'h3F),
      .tach_o(tach_in_i)
   );

   // ------------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Inputs always move 1 ns after the rising edge so no edge races the driver.
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   function automatic logic [8:0] dy(input int c);
      return duty_o[9*c +: 9];
   endfunction

   task automatic wr(input int c, input logic [8:0] d);
      duty_wdata_i = d;
      duty_wr_i = 6'h01 << c;
      cyc(1);
      duty_wr_i = 6'h00;
   endtask

   task automatic fev(input logic [5:0] ev, input logic [5:0] clr);
      fault_event_i = ev;
      fault_clear_i = clr;
      cyc(1);
      fault_event_i = 6'h00;
      fault_clear_i = 6'h00;
      cyc(3);
   endtask

   // Spacing of two rising edges of the clock output, in core cycles.
   task automatic per(output int q);
      int t0;
      @(posedge osc_clock_out_o);
      #1;
      t0 = cyc_n;
      @(posedge osc_clock_out_o);
      #1;
      q = cyc_n - t0;
   endtask

   task automatic close_out();
      $display("Checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Watchdog sized at nearly four times the expected run length.
   initial begin
      #400000;
      error_cnt++;
      close_out();
   end

   // ------------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------------
   initial begin
      cyc(10);
      check("reset_oe", {fan_pwm_out_oe_o, fan_fault_n_oe_o}, 32'h0);
      check("reset_duty", duty_o[31:0], 32'h0);
      check("od_data", {fan_pwm_out_o, fan_fault_n_o, crystal_out_o}, 32'h0);
      rst_i = 1'b0;
      cyc(20);
      for (int c = 0; c < 6; c++) check("pu_duty", dy(c), 32'h133);
      $display("reset test done");
      // Table rows: value written to channel i and the duty it must show.
      for (int i = 0; i < 6; i++) begin
         wr(i, ROWS[i]);
         cyc(3);
         check("duty_row", dy(i), ROWS[i]);
      end
      check("pin_low_at_zero", fan_pwm_out_oe_o[1], 32'h1);
      check("pin_free_at_full", fan_pwm_out_oe_o[0], 32'h0);
      $display("table test done");
      // Force in standby with 250 ms spacing between channel starts.
      standby_i = 1'b1;
      cyc(3);
      force_max_n_i = 1'b0;
      for (int c = 0; c < 6; c++) begin
         for (int k = 0; k < 4000 && dy(c) !== 9'h1FF; k++) cyc(1);
         t[c] = cyc_n;
         check("force_full", dy(c), 32'h1FF);
         if (c > 0) check("seq_gap", {31'h0, (t[c] - t[c-1]) inside {[2490:2510]}}, 32'h1);
      end
      cyc(2);
      check("force_pins", fan_pwm_out_oe_o, 32'h0);
      zero_on_fail_i = 6'h04;
      fev(6'h04, 6'h00);
      check("failed_zero", dy(2), 32'h0);
      check("others_full", dy(3), 32'h1FF);
      check("fault_pin_on", fan_fault_n_oe_o, 32'h1);
      fev(6'h00, 6'h04);
      check("fault_pin_off", fan_fault_n_oe_o, 32'h0);
      check("cleared_full", dy(2), 32'h1FF);
      force_max_n_i = 1'b1;
      standby_i = 1'b0;
      zero_on_fail_i = 6'h00;
      $display("force test done");
      // Two detections needed; then a masked fan must not reach the pin.
      fault_limit_sel_i = 2'h1;
      fev(6'h01, 6'h00);
      check("one_detect", {fan_failed_o, fan_fault_n_oe_o}, 32'h0);
      fev(6'h01, 6'h00);
      check("two_detect", {fan_failed_o, fan_fault_n_oe_o}, 32'h03);
      fev(6'h00, 6'h01);
      fault_limit_sel_i = 2'h0;
      fault_mask_i = 6'h10;
      fev(6'h10, 6'h00);
      check("masked", {fan_failed_o, fan_fault_n_oe_o}, 32'h20);
      fev(6'h00, 6'h10);
      fault_mask_i = 6'h00;
      $display("fault test done");
      // Forced duty on channel 2 climbs at 1 ms per step, not at once.
      rate_sel_i = 18'h00008;
      seq_delay_sel_i = 3'h0;
      cyc(5);
      force_max_n_i = 1'b0;
      cyc(110);
      check("ramp", {31'h0, dy(1) inside {[9'h008:9'h00C]}}, 32'h1);
      check("no_delay_full", dy(5), 32'h1FF);
      force_max_n_i = 1'b1;
      pwm_as_tach_i = 6'h02;
      // Channel 4 runs the loop against a short target, so each tach period adds one.
      rpm_mode_i = 6'h08;
      tach_target_i[43:33] = 11'h010;
      cyc(1500);
      check("as_tach_oe", fan_pwm_out_oe_o[1], 32'h0);
      check("tach_pin", {31'h0, tach_count_o[21:11] inside {[11'h031:11'h033]}}, 32'h1);
      check("tach_ded", {31'h0, tach_count_o[43:33] inside {[11'h031:11'h033]}}, 32'h1);
      check("rpm_raise", {31'h0, dy(3) inside {[9'h136:9'h137]}}, 32'h1);
      $display("tach test done");
      per(p);
      check("osc_int", p, 32'h1DCC);
      crystal_enable_i = 1'b1;
      cyc(10);
      per(p);
      check("osc_xtal", p, 32'h28);
      check("xtal_drive", crystal_out_o ^ osc_clock_out_o, 32'h1);
      $display("clock test done");
      close_out();
   end
endmodule // fpc_top_tb
